// ==== bench/dpah_dev_model.sv ====
// Behavioural model of one port of the two-port memory with token flags
`timescale 1ns/100ps
module dpah_dev_model (
    // Sampling clock
    input  wire logic        pclk,
    // Port pins
    input  wire logic        mem_ce_n,
    input  wire logic        mem_rw_n,
    input  wire logic        mem_oe_n,
    input  wire logic        flag_space_select_n,
    input  wire logic [16:0] mem_addr,
    input  wire logic [7:0]  mem_dq_o,
    input  wire logic        mem_dq_oe,
    output logic      [7:0]  mem_dq_i,
    output logic             mem_hold_n,
    output logic             mem_alert_n,
    // Far port stand-ins
    input  wire logic        hold_req,
    input  wire logic        far_write_top,
    output logic             far_alert
);
    logic [7:0] mem [logic [16:0]];
    logic [7:0] flag_q = 8'hFF;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rd_val;
    logic       is_flag, drive;
    logic       alert_q = 1'b0;
    logic       far_q = 1'b0;
    wire logic  win = !mem_rw_n && !(mem_ce_n && flag_space_select_n);
    // slave role, hold comes from outside
    assign mem_hold_n = !hold_req;
    assign mem_alert_n = !alert_q;
    assign far_alert = far_q;
    // drive on reads only, a flag fills all lines
    always_comb begin
        drive = mem_rw_n && !mem_oe_n && !(mem_ce_n && flag_space_select_n);
        rd_val = !flag_space_select_n ? {8{flag_q[mem_addr[2:0]]}}
               : (mem.exists(mem_addr) ? mem[mem_addr] : 8'hFF);
        mem_dq_i = drive ? rd_val : ~last_q; // Released bus keeps moving
    end
    always @(posedge win) is_flag = !flag_space_select_n;
    // commit at end of overlap, not while held
    always @(negedge win) begin
        // one writer here, so a flag write lands unless hold is low
        if (mem_hold_n && mem_dq_oe && is_flag)
            flag_q[mem_addr[2:0]] = mem_dq_o[0];
        else if (mem_hold_n && mem_dq_oe) begin
            mem[mem_addr] = mem_dq_o;
            if (mem_addr == 17'h1FFFF)
                far_q = 1'b1;
        end
    end
    // far write sets the alert, a local read of the box clears it
    always @(posedge pclk) begin
        last_q <= mem_dq_i;
        if (far_write_top)
            alert_q <= 1'b1;
        else if (drive && flag_space_select_n && mem_addr == 17'h1FFFE)
            alert_q <= 1'b0;
    end
endmodule

// ==== bench/dpah_props.sv ====
// Checker of the pin rules that bind the memory host controller
`timescale 1ns/100ps
module dpah_props #(
    parameter int AW = 17
) (
    // Clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // Memory pins
    input wire logic          mem_ce_n,
    input wire logic          mem_rw_n,
    input wire logic          mem_oe_n,
    input wire logic          flag_space_select_n,
    input wire logic [AW-1:0] mem_addr,
    input wire logic          mem_hold_n
);
    // Either select low means the port is selected
    wire logic sel_n = mem_ce_n & flag_space_select_n;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_addr_quiet;
        !$stable(mem_addr) |-> (mem_rw_n || sel_n) && $past(mem_rw_n || sel_n);
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("address moved inside a write window");
    property p_one_space;
        mem_ce_n || flag_space_select_n;
    endproperty
    a_one_space: assert property (p_one_space)
        else $error("array and flag space selected together");
    property p_sel_hold;
        $fell(sel_n) && !mem_rw_n |-> (!sel_n && !mem_rw_n)[*2];
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("write overlap shorter than two cycles");
    property p_pulse_oe;
        $fell(sel_n) && !mem_rw_n && !mem_oe_n |-> (!sel_n && !mem_rw_n)[*3];
    endproperty
    a_pulse_oe: assert property (p_pulse_oe)
        else $error("write pulse too short with output enable low");
    property p_flag_gap;
        $rose(flag_space_select_n) && !$past(mem_rw_n) |=> flag_space_select_n;
    endproperty
    a_flag_gap: assert property (p_flag_gap)
        else $error("flag read back too soon after flag write");
    property p_held_block;
        (!mem_hold_n)[*3] ##0 !mem_rw_n |=> !mem_rw_n;
    endproperty
    a_held_block: assert property (p_held_block)
        else $error("strobe released while hold low");
    property p_hold_after;
        $rose(mem_hold_n) && !mem_rw_n && !sel_n |-> (!mem_rw_n)[*4];
    endproperty
    a_hold_after: assert property (p_hold_after)
        else $error("strobe released too soon after hold");
endmodule

bind dpah_ctrl dpah_props #(.AW(AW)) u_props (
    .pclk(pclk), .presetn(presetn), .mem_ce_n(mem_ce_n),
    .mem_rw_n(mem_rw_n), .mem_oe_n(mem_oe_n),
    .flag_space_select_n(flag_space_select_n), .mem_addr(mem_addr),
    .mem_hold_n(mem_hold_n)
);

// ==== bench/dual_port_ram_write_arbitration_tb.sv ====
// Self-checking bench for the memory host controller
`timescale 1ns/100ps
module dual_port_ram_write_arbitration_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, mem_dq_i, mem_dq_o;
    logic [31:0] pwdata, prdata, rv;
    logic        mem_ce_n, mem_rw_n, mem_oe_n, flag_space_select_n, ev;
    logic        mem_dq_oe, mem_hold_n, mem_alert_n;
    logic [16:0] mem_addr;
    logic        hold_req, far_write_top, far_alert;
    int          err_count = 0;
    int          n_tests = 0;

    dpah_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_ce_n(mem_ce_n),
        .mem_rw_n(mem_rw_n), .mem_oe_n(mem_oe_n),
        .flag_space_select_n(flag_space_select_n), .mem_addr(mem_addr),
        .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
        .mem_hold_n(mem_hold_n), .mem_alert_n(mem_alert_n));
    dpah_dev_model dev (
        .pclk(pclk), .mem_ce_n(mem_ce_n), .mem_rw_n(mem_rw_n),
        .mem_oe_n(mem_oe_n), .flag_space_select_n(flag_space_select_n),
        .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
        .mem_dq_i(mem_dq_i), .mem_hold_n(mem_hold_n),
        .mem_alert_n(mem_alert_n), .hold_req(hold_req),
        .far_write_top(far_write_top), .far_alert(far_alert));

    // ********************************
    // Bus tasks
    // ********************************
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Idle edge first so no signal is set twice in one step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            finish_test();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        for (int n = 0; n < 40; n++) begin
            apb(1'b0, dpah_pkg::REG_STATUS, 32'h0);
            if (rv[b] === v)
                return;
        end
        err_count++;
        finish_test();
    endtask
    task automatic start_op(input logic [3:0] c, input logic [16:0] a,
                            input logic [7:0] d);
        apb(1'b1, dpah_pkg::REG_ADDR, {15'h0, a});
        apb(1'b1, dpah_pkg::REG_WDATA, {24'h0, d});
        apb(1'b1, dpah_pkg::REG_CTRL, {28'h0, c | 4'h1});
    endtask
    task automatic end_op();
        poll(dpah_pkg::ST_DONE, 1'b1);
        apb(1'b1, dpah_pkg::REG_STATUS, 32'h0000_0002);
    endtask
    task automatic rd_mem(input logic [3:0] c, input logic [16:0] a);
        start_op(c, a, 8'h00);
        end_op();
        apb(1'b0, dpah_pkg::REG_RDATA, 32'h0);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs();
        apb(1'b0, dpah_pkg::REG_CTRL, 32'h0);
        check("ctrl", rv, dpah_pkg::CTRL_RST);
        apb(1'b0, dpah_pkg::REG_STATUS, 32'h0);
        check("status", rv, dpah_pkg::ZERO_WORD);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        check("slverr", {31'h0, ev}, 32'h1);
    endtask
    // Plain write, then one with output enable low
    task automatic t_array();
        start_op(4'h2, 17'h00123, 8'h3C);
        end_op();
        start_op(4'hA, 17'h00124, 8'hC3);
        end_op();
        rd_mem(4'h0, 17'h00123);
        check("array0", rv, 32'h3C);
        rd_mem(4'h0, 17'h00124);
        check("array1", rv, 32'hC3);
    endtask
    // Upper address bits must not select another flag
    task automatic t_flag();
        start_op(4'h6, 17'h00003, 8'hFE);
        end_op();
        rd_mem(4'h4, 17'h1FFF3);
        check("flag3", rv, 32'h00);
        rd_mem(4'h4, 17'h00002);
        check("flag2", rv, 32'hFF);
        apb(1'b0, dpah_pkg::REG_STATUS, 32'h0);
        check("lines", rv & 32'h10, 32'h0);
    endtask
    task automatic t_hold();
        hold_req <= 1'b1; // far side won the match
        start_op(4'h2, 17'h00200, 8'h5A);
        poll(dpah_pkg::ST_STALLED, 1'b1);
        check("stall", rv & 32'h27, 32'h25);
        check("early", {31'h0, dev.mem.exists(17'h00200) > 0}, 32'h0);
        hold_req <= 1'b0;
        end_op();
        rd_mem(4'h0, 17'h00200);
        check("late", rv, 32'h5A);
    endtask
    task automatic t_alert();
        far_write_top <= 1'b1;
        @(posedge pclk);
        far_write_top <= 1'b0;
        poll(dpah_pkg::ST_ALERT, 1'b1);
        check("alert", rv & 32'h8, 32'h8);
        rd_mem(4'h0, 17'h1FFFE);
        apb(1'b0, dpah_pkg::REG_STATUS, 32'h0);
        check("alertclr", rv & 32'h8, 32'h0);
        start_op(4'h2, 17'h1FFFF, 8'h11);
        end_op();
        check("faralert", {31'h0, far_alert}, 32'h1);
    endtask

    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, hold_req, far_write_top} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_array();
        t_flag();
        t_hold();
        t_alert();
        finish_test();
    end
endmodule

// ==== design/dpah_ctrl.sv ====
// Host controller driving one port of a two-port memory, APB programmed
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module dpah_ctrl #(
    parameter int AW = 17,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Memory port pins
    output logic               mem_ce_n,
    output logic               mem_rw_n,
    output logic               mem_oe_n,
    output logic               flag_space_select_n,
    output logic      [AW-1:0] mem_addr,
    input  wire logic [DW-1:0] mem_dq_i,
    output logic      [DW-1:0] mem_dq_o,
    output logic               mem_dq_oe,
    input  wire logic          mem_hold_n,
    input  wire logic          mem_alert_n
);

    // ************************************************************
    // Declarations
    // ************************************************************
    dpah_pkg::dpah_state_t state_q;

    logic [31:0]   ctrl_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] rdata_q;
    logic          done_q;
    logic          flagbad_q;
    logic          stalled_q;
    logic          op_wr_q;
    logic          op_flag_q;
    logic          op_oew_q;

    logic [DW-1:0] dq_s;
    logic          hold_n_s;
    logic          alert_n_s;

    logic                          tmr_load;
    logic [dpah_pkg::TMR_W-1:0]    tmr_count;
    logic                          tmr_exp;

    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic go;
    logic done_set;
    logic done_clr;

    // Register decode, shared by read and write paths
    function automatic logic addr_hit(input logic [7:0] a);
        if (a == dpah_pkg::REG_CTRL) begin
            return 1'b1;
        end else if (a == dpah_pkg::REG_ADDR) begin
            return 1'b1;
        end else if (a == dpah_pkg::REG_WDATA) begin
            return 1'b1;
        end else if (a == dpah_pkg::REG_RDATA) begin
            return 1'b1;
        end else if (a == dpah_pkg::REG_STATUS) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // ************************************************************
    // Pin synchronisers and phase timer
    // ************************************************************
    dpah_sync #(.W(DW), .RST_VAL('0)) u_sync_dq (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (mem_dq_i),
        .q       (dq_s)
    );

    dpah_sync #(.W(2), .RST_VAL(2'h3)) u_sync_ctl (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({mem_hold_n, mem_alert_n}),
        .q       ({hold_n_s, alert_n_s})
    );

    dpah_timer #(.W(dpah_pkg::TMR_W)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tmr_load),
        .count   (tmr_count),
        .expired (tmr_exp)
    );

    // ************************************************************
    // APB slave
    // ************************************************************
    // Access completes in the second access cycle; ready is registered
    assign acc    = psel && penable && !pready;
    assign wr_acc = acc && pwrite && addr_hit(paddr);
    assign rd_acc = acc && !pwrite && addr_hit(paddr);
    assign go     = wr_acc && (paddr == dpah_pkg::REG_CTRL) &&
                    pwdata[dpah_pkg::CTRL_GO] && (state_q == dpah_pkg::ST_IDLE);
    assign done_clr = wr_acc && (paddr == dpah_pkg::REG_STATUS) &&
                      pwdata[dpah_pkg::ST_DONE];

    // Handshake and error answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !addr_hit(paddr);
        end
    end

    // Read data mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= dpah_pkg::ZERO_WORD;
        end else if (rd_acc) begin
            if (paddr == dpah_pkg::REG_CTRL) begin
                prdata <= ctrl_q;
            end else if (paddr == dpah_pkg::REG_ADDR) begin
                prdata <= 32'(addr_q);
            end else if (paddr == dpah_pkg::REG_WDATA) begin
                prdata <= 32'(wdata_q);
            end else if (paddr == dpah_pkg::REG_RDATA) begin
                prdata <= 32'(rdata_q);
            end else begin
                prdata <= dpah_pkg::ZERO_WORD;
                prdata[dpah_pkg::ST_ACTIVE]  <= state_q != dpah_pkg::ST_IDLE;
                prdata[dpah_pkg::ST_DONE]    <= done_q;
                prdata[dpah_pkg::ST_HOLD]    <= !hold_n_s;
                prdata[dpah_pkg::ST_ALERT]   <= !alert_n_s;
                prdata[dpah_pkg::ST_FLAGBAD] <= flagbad_q;
                prdata[dpah_pkg::ST_STALLED] <= stalled_q;
            end
        end else begin
            prdata <= dpah_pkg::ZERO_WORD;
        end
    end

    // Software registers; address and data are frozen while a cycle runs
    // because the pins must not move under an active select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= dpah_pkg::CTRL_RST;
            addr_q  <= '0;
            wdata_q <= '0;
        end else if (wr_acc && state_q == dpah_pkg::ST_IDLE) begin
            if (paddr == dpah_pkg::REG_CTRL) begin
                ctrl_q <= pwdata & ~(32'h1 << dpah_pkg::CTRL_GO);
            end else if (paddr == dpah_pkg::REG_ADDR) begin
                addr_q <= pwdata[AW-1:0];
            end else if (paddr == dpah_pkg::REG_WDATA) begin
                wdata_q <= pwdata[DW-1:0];
            end
        end
    end

    // Done flag: a completion in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (done_clr) begin
            done_q <= 1'b0;
        end
    end

    // ************************************************************
    // Pin sequencer
    // ************************************************************
    assign done_set = (state_q == dpah_pkg::ST_RECOV) && tmr_exp;

    // Timer loads on each phase change except SETUP to ENAB and RECOV to IDLE
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = '0;
        case (state_q)
            dpah_pkg::ST_IDLE: begin
                tmr_load  = go;
                tmr_count = dpah_pkg::TMR_W'(dpah_pkg::AS_CYC);
            end
            dpah_pkg::ST_SETUP: begin
                // Read waits the access time plus the data synchroniser
                tmr_load  = tmr_exp && !op_wr_q;
                tmr_count = dpah_pkg::TMR_W'(dpah_pkg::RD_CYC +
                                            dpah_pkg::SYNC_CYC);
            end
            dpah_pkg::ST_ENAB: begin
                tmr_load  = 1'b1;
                tmr_count = op_oew_q ?
                            dpah_pkg::TMR_W'(dpah_pkg::PWO_CYC) :
                            dpah_pkg::TMR_W'(dpah_pkg::PW_CYC);
            end
            dpah_pkg::ST_STROBE: begin
                // hold after release, counted from the synced edge
                tmr_load  = !hold_n_s;
                tmr_count = dpah_pkg::TMR_W'(dpah_pkg::WH_CYC +
                                            dpah_pkg::SYNC_CYC);
                if (tmr_exp && hold_n_s) begin
                    tmr_load  = 1'b1;
                    tmr_count = op_flag_q ?
                                dpah_pkg::TMR_W'(dpah_pkg::SWRD_CYC) :
                                dpah_pkg::TMR_W'(dpah_pkg::AS_CYC);
                end
            end
            dpah_pkg::ST_RDWAIT: begin
                tmr_load  = tmr_exp;
                tmr_count = dpah_pkg::TMR_W'(dpah_pkg::AS_CYC);
            end
            default: begin
                tmr_load  = 1'b0;
            end
        endcase
    end

    // State, operation latch and pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q             <= dpah_pkg::ST_IDLE;
            op_wr_q             <= 1'b0;
            op_flag_q           <= 1'b0;
            op_oew_q            <= 1'b0;
            mem_ce_n            <= 1'b1;
            mem_rw_n            <= 1'b1;
            mem_oe_n            <= 1'b1;
            flag_space_select_n <= 1'b1;
            mem_addr            <= '0;
            mem_dq_o            <= '0;
            mem_dq_oe           <= 1'b0;
        end else begin
            case (state_q)
                dpah_pkg::ST_IDLE: begin
                    if (go) begin
                        // address moves only with every strobe high
                        mem_addr  <= addr_q;
                        op_wr_q   <= pwdata[dpah_pkg::CTRL_WRITE];
                        op_flag_q <= pwdata[dpah_pkg::CTRL_FLAG];
                        op_oew_q  <= pwdata[dpah_pkg::CTRL_OEW];
                        state_q   <= dpah_pkg::ST_SETUP;
                    end
                end
                dpah_pkg::ST_SETUP: begin
                    if (tmr_exp) begin
                        if (op_wr_q) begin
                            mem_rw_n  <= 1'b0;
                            mem_oe_n  <= !op_oew_q;
                            mem_dq_o  <= wdata_q;
                            mem_dq_oe <= 1'b1;
                            state_q   <= dpah_pkg::ST_ENAB;
                        end else begin
                            mem_ce_n            <= op_flag_q;
                            flag_space_select_n <= !op_flag_q;
                            mem_oe_n            <= 1'b0;
                            state_q             <= dpah_pkg::ST_RDWAIT;
                        end
                    end
                end
                dpah_pkg::ST_ENAB: begin
                    mem_ce_n            <= op_flag_q;
                    flag_space_select_n <= !op_flag_q;
                    state_q             <= dpah_pkg::ST_STROBE;
                end
                dpah_pkg::ST_STROBE: begin
                    // strobe kept low while hold is low
                    if (tmr_exp && hold_n_s) begin
                        mem_rw_n            <= 1'b1;
                        mem_oe_n            <= 1'b1;
                        mem_ce_n            <= 1'b1;
                        flag_space_select_n <= 1'b1;
                        state_q             <= dpah_pkg::ST_RECOV;
                    end
                end
                dpah_pkg::ST_RDWAIT: begin
                    if (tmr_exp) begin
                        mem_oe_n            <= 1'b1;
                        mem_ce_n            <= 1'b1;
                        flag_space_select_n <= 1'b1;
                        state_q             <= dpah_pkg::ST_RECOV;
                    end
                end
                dpah_pkg::ST_RECOV: begin
                    // Data released after the strobe, zero hold met
                    mem_dq_oe <= 1'b0;
                    if (tmr_exp) begin
                        state_q <= dpah_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= dpah_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read capture and flag check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q   <= '0;
            flagbad_q <= 1'b0;
        end else if (state_q == dpah_pkg::ST_RDWAIT && tmr_exp) begin
            rdata_q <= dq_s;
            // all lines equal on a flag read
            flagbad_q <= op_flag_q && (dq_s != {DW{dq_s[0]}});
        end
    end

    // Stall seen during the last write, for software diagnosis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stalled_q <= 1'b0;
        end else if (go) begin
            stalled_q <= 1'b0;
        end else if (state_q == dpah_pkg::ST_STROBE && !hold_n_s) begin
            stalled_q <= 1'b1;
        end
    end

endmodule

// ==== design/dpah_pkg.sv ====
// Constants, register map, timing and states of the dual-port memory host
// Operation
// - Host keeps strobe or select high whenever the address changes.
// - Host picks array or flag space and holds it for the enable interval.
// - With output drive low, strobe lasts max(pulse width, turn-off plus set-up).
// - Host waits the flag write-to-read interval before reading a flag back.
// - Host keeps its strobe low for the hold-release interval afterwards.
// - In slave role external hold must lead the write, zero minimum.
package dpah_pkg;

    // ************************************************************
    // Register map, word offsets on APB
    // ************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // CTRL fields
    localparam int CTRL_GO    = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_FLAG  = 2;
    localparam int CTRL_OEW   = 3;
    // STATUS fields
    localparam int ST_ACTIVE  = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_HOLD    = 2;
    localparam int ST_ALERT   = 3;
    localparam int ST_FLAGBAD = 4;
    localparam int ST_STALLED = 5;

    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ************************************************************
    // Timing, printed figures and derived cycle counts
    // ************************************************************
    localparam int CLK_PS      = 8000;
    localparam int T_AS_NS     = 0;   // Address set-up
    localparam int T_EW_NS     = 12;  // Enable to end of write
    localparam int T_WP_NS     = 12;  // Write pulse width
    localparam int T_WZ_NS     = 10;  // Strobe to outputs off
    localparam int T_DW_NS     = 10;  // Data valid to end of write
    localparam int T_WH_NS     = 12;  // write_hold_after_release
    localparam int T_SWRD_NS   = 5;   // Flag write to read
    localparam int T_AA_NS     = 15;  // Read access

    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int AS_CYC   = ceil_cyc(T_AS_NS);
    localparam int PW_CYC   = ceil_cyc((T_EW_NS > T_WP_NS) ? T_EW_NS : T_WP_NS);
    localparam int PWO_CYC  = ceil_cyc((T_WZ_NS + T_DW_NS > T_WP_NS) ?
                                       T_WZ_NS + T_DW_NS : T_WP_NS);
    localparam int WH_CYC   = ceil_cyc(T_WH_NS);
    localparam int SWRD_CYC = ceil_cyc(T_SWRD_NS);
    localparam int RD_CYC   = ceil_cyc(T_AA_NS);
    localparam int SYNC_CYC = 2;

    localparam int TMR_W = 4;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_SETUP  = 6'b000010,
        ST_ENAB   = 6'b000100,
        ST_STROBE = 6'b001000,
        ST_RDWAIT = 6'b010000,
        ST_RECOV  = 6'b100000
    } dpah_state_t;

endpackage

// ==== design/dpah_sync.sv ====
// Two-flop synchroniser for pins from the asynchronous memory
`timescale 1ns/100ps
module dpah_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ==== design/dpah_timer.sv ====
// Down-counter that times pin phases in whole clock cycles
`timescale 1ns/100ps
module dpah_timer #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              expired
);

    logic [W-1:0] cnt_q;

    // Load wins over counting so a phase can be restarted at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Free of load: the sequencer loads on expiry, so no comb loop forms
    assign expired = (cnt_q == '0);

endmodule
